// [cms_consts.svh]
/*
 * Register offsets, reset values, write masks and scaling constants
 * of the charger mask and set-point register bank.
 * Assumes inclusion by cms_regs_top by bare name.
 */
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

// Register offsets on the internal register port.
`define CMS_ADDR_CHG_MASK    8'h0B
`define CMS_ADDR_TMR_MASK    8'h0C
`define CMS_ADDR_BST_MASK    8'h0D
`define CMS_ADDR_VBAT_SET    8'h0E
`define CMS_ADDR_CHARGE_CURRENT_SETPOINT    8'h0F
`define CMS_ADDR_MISC_SET    8'h10
`define CMS_ADDR_ADAPTER_INPUT_LIMIT  8'h11

// Reset values of the registers.
`define CMS_RST_CHG_MASK     8'h00
`define CMS_RST_TMR_MASK     8'h0E
`define CMS_RST_BST_MASK     8'h1F
`define CMS_RST_VBAT_SET     8'h0C
`define CMS_RST_CHARGE_CURRENT_SETPOINT     8'h26
`define CMS_RST_MISC_SET     8'h2C
`define CMS_RST_ADAPTER_INPUT_LIMIT   8'h00

// Writable bits of each register; the others read zero.
`define CMS_WM_CHG_MASK      8'h1B
`define CMS_WM_TMR_MASK      8'h0E
`define CMS_WM_BST_MASK      8'h1F
`define CMS_WM_VBAT_SET      8'h3F
`define CMS_WM_CHARGE_CURRENT_SETPOINT      8'hFF
`define CMS_WM_MISC_SET      8'h7F
`define CMS_WM_ADAPTER_INPUT_LIMIT    8'hF0

// Number of registers in the bank.
`define CMS_NUM_REGS         7
`define CMS_IDX_CHG          0
`define CMS_IDX_TMR          1
`define CMS_IDX_BST          2
`define CMS_IDX_VBAT         3
`define CMS_IDX_IBAT         4
`define CMS_IDX_MISC         5
`define CMS_IDX_BUS_INPUT_CURRENT_LIMIT       6

// Scaling of the set-point codes, in mV or mA.
`define CMS_VBAT_BASE_MV     13'hCE4
`define CMS_VBAT_STEP_MV     13'h019
`define CMS_CHARGE_CURRENT_CODE_BASE_MA     13'h1C2
`define CMS_CHARGE_CURRENT_CODE_STEP_MA     13'h064
`define CMS_CHARGE_CURRENT_HIGH_RANGE_MA     13'h640
`define CMS_END_OF_CHARGE_CURRENT_BASE_MA     13'h064
`define CMS_END_OF_CHARGE_CURRENT_STEP_MA     13'h019
`define CMS_WEAK_BATTERY_CURRENT_STEP_MA    13'h064
`define CMS_VFET_BASE_MV     13'hC1C
`define CMS_VFET_STEP_MV     13'h064
`define CMS_IIN_LIM0_MA      13'h064
`define CMS_IIN_LIM1_MA      13'h1F4
`define CMS_IIN_LIM2_MA      13'h384
`define CMS_IIN_LIM3_MA      13'h5DC
`define CMS_IIN_TA_BASE_MA   13'h1F4
`define CMS_IIN_TA_STEP_MA   13'h064

`endif

// [cms_pkg.sv]
/*
 * Types of the charger mask and set-point register bank.
 * Assumes cms_consts.svh is on the include path.
 */
package cms_pkg;
	// Event bits in the order of the three mask registers.
	typedef struct packed {
		logic input_low;
		logic input_high;
		logic buck_overvoltage;
		logic charge_state_change;
		logic watchdog_timeout;
		logic input_bus_timeout;
		logic charge_timeout;
		logic boost_overload_level2;
		logic boost_overload_level1;
		logic bus_overvoltage;
		logic battery_out_of_range;
		logic boost_state_change;
	} cms_evt_t;

	// Raw set-point fields as held in the registers.
	typedef struct packed {
		logic [5:0] battery_voltage_code;
		logic       charge_current_high_range;
		logic [2:0] end_of_charge_current;
		logic [3:0] charge_current_code;
		logic [1:0] weak_battery_current;
		logic [2:0] reconnect_threshold;
		logic [1:0] bus_input_current_limit;
		logic [3:0] adapter_input_current_limit;
	} cms_setpoint_t;

	// Set-points decoded to physical values, mV or mA.
	typedef struct packed {
		logic [12:0] battery_voltage_mv;
		logic [12:0] charge_current_ma;
		logic [12:0] end_of_charge_ma;
		logic [12:0] weak_battery_ma;
		logic [12:0] reconnect_mv;
		logic [12:0] input_limit_ma;
	} cms_phys_t;
endpackage

// [cms_reg8.sv]
/*
 * One 8-bit register of the bank with per-bit write mask.
 * Assumes a synchronous active-high reset and a clear from other sources.
 */
`timescale 1ns/100ps
module cms_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WR_MASK   = 8'hFF
) (
	// Clock and resets.
	input  wire logic       i_sys_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clear,
	// Write port.
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	// Stored value.
	output logic      [7:0] o_q
);
	logic [7:0] q_reg;
	logic [7:0] q_next;

	// Defaults win over a write in the same cycle; masked bits stay zero.
	assign q_next = (i_sys_rst || i_clear) ? (RESET_VAL & WR_MASK) :
		i_wr ? (i_wdata & WR_MASK) : q_reg;

	// Storage flip-flops.
	always_ff @(posedge i_sys_clk)
	begin
		q_reg <= q_next;
	end

	assign o_q = q_reg;
endmodule

// [cms_regs_top.sv]
/*
 * Charger mask and set-point register bank: three event mask registers
 * and four charge set-point registers behind an internal register port.
 * Assumes the two-wire bus transport sits outside and presents one-cycle
 * read and write strobes with an 8-bit address, synchronous to i_sys_clk.
 */
`timescale 1ns/100ps
`include "cms_consts.svh"
module cms_regs_top (
	// Clock and power-on reset.
	input  wire logic              i_sys_clk,
	input  wire logic              i_sys_rst,
	// Further default sources, level or pulse.
	input  wire logic              i_off_state,
	input  wire logic              i_reg_reset_cmd,
	input  wire logic              i_boost_mode_entry,
	// Internal register port from the bus transport.
	input  wire logic        [7:0] i_reg_addr,
	input  wire logic              i_reg_wr,
	input  wire logic        [7:0] i_reg_wdata,
	input  wire logic              i_reg_rd,
	output logic             [7:0] o_reg_rdata,
	output logic                   o_reg_rvalid,
	output logic                   o_reg_hit,
	// Raw events, their masked copies for the flag logic, and the masks.
	input  wire cms_pkg::cms_evt_t i_events,
	output cms_pkg::cms_evt_t      o_flag_events,
	output cms_pkg::cms_evt_t      o_mask,
	// Set-points to the regulation loops.
	output cms_pkg::cms_setpoint_t o_setpoint,
	output cms_pkg::cms_phys_t     o_phys
);
	import cms_pkg::*;

	localparam int NREG = `CMS_NUM_REGS;

	// Register map, seen from the internal register port:
	//   0x0B charger event masks, 0x0C timer event masks,
	//   0x0D boost event masks, 0x0E battery voltage set-point,
	//   0x0F charge current set-point, 0x10 weak-battery, reconnect
	//   and bus input limit, 0x11 adapter input limit.
	// Timing of the register port:
	//   A read strobe is taken on a rising edge; the data, the hit flag
	//   and a one-cycle valid pulse leave flip-flops at that same edge.
	//   A write lands in storage at the edge that takes it; the mask,
	//   set-point and physical outputs follow one edge later.
	// Hazards and limits:
	//   Any default source that is high wins over a write in the same
	//   cycle, so the host must repeat a write that met such a source.
	//   Reserved bits are masked to zero on every load of storage, which keeps them at zero
	//   through every write and every reset source.
	//   Codes above the documented top are stored as written and give
	//   an extrapolated physical value; keeping to the range is the
	//   host's duty.

	// Address, reset and write-mask tables, one entry per register.
	localparam logic [NREG-1:0][7:0] ADDR_TAB = {
		`CMS_ADDR_ADAPTER_INPUT_LIMIT, `CMS_ADDR_MISC_SET, `CMS_ADDR_CHARGE_CURRENT_SETPOINT,
		`CMS_ADDR_VBAT_SET, `CMS_ADDR_BST_MASK, `CMS_ADDR_TMR_MASK,
		`CMS_ADDR_CHG_MASK};
	localparam logic [NREG-1:0][7:0] RST_TAB = {
		`CMS_RST_ADAPTER_INPUT_LIMIT, `CMS_RST_MISC_SET, `CMS_RST_CHARGE_CURRENT_SETPOINT,
		`CMS_RST_VBAT_SET, `CMS_RST_BST_MASK, `CMS_RST_TMR_MASK,
		`CMS_RST_CHG_MASK};
	localparam logic [NREG-1:0][7:0] WM_TAB = {
		`CMS_WM_ADAPTER_INPUT_LIMIT, `CMS_WM_MISC_SET, `CMS_WM_CHARGE_CURRENT_SETPOINT,
		`CMS_WM_VBAT_SET, `CMS_WM_BST_MASK, `CMS_WM_TMR_MASK,
		`CMS_WM_CHG_MASK};

	logic [NREG-1:0][7:0] reg_q;
	logic [NREG-1:0][7:0] rd_term;
	logic [NREG-1:0]      addr_hit;
	logic                 clear_req;
	logic [7:0]           rd_mux;
	logic [7:0]           rdata_reg;
	logic [7:0]           rdata_next;
	logic                 rvalid_reg;
	logic                 hit_reg;
	logic                 hit_next;

	// Any default source other than power-on reset restores the bank.
	assign clear_req = i_off_state | i_reg_reset_cmd | i_boost_mode_entry;

	// One register per table entry, with its own decode.
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++)
		begin : g_reg
			assign addr_hit[gi] = (i_reg_addr == ADDR_TAB[gi]);
			assign rd_term[gi]  = addr_hit[gi] ? reg_q[gi] : 8'h00;
			cms_reg8 #(
				.RESET_VAL (RST_TAB[gi]),
				.WR_MASK   (WM_TAB[gi])
			) u_reg (
				.i_sys_clk (i_sys_clk),
				.i_sys_rst (i_sys_rst),
				.i_clear   (clear_req),
				.i_wr      (i_reg_wr & addr_hit[gi]),
				.i_wdata   (i_reg_wdata),
				.o_q       (reg_q[gi])
			);
		end
	endgenerate

	// OR of the decoded terms; an unmapped address reads zero.
	always_comb
	begin
		rd_mux = 8'h00;
		for (int k = 0; k < NREG; k++)
		begin
			rd_mux = rd_mux | rd_term[k];
		end
	end

	// Read answer next cycle; reserved bits are zero in storage.
	assign rdata_next = i_reg_rd ? rd_mux : rdata_reg;
	assign hit_next   = (i_reg_rd || i_reg_wr) ? (|addr_hit) : hit_reg;

	// Mask fields taken from the three mask registers.
	cms_evt_t mask_w;
	assign mask_w.input_low             = reg_q[`CMS_IDX_CHG][4];
	assign mask_w.input_high            = reg_q[`CMS_IDX_CHG][3];
	assign mask_w.buck_overvoltage      = reg_q[`CMS_IDX_CHG][1];
	assign mask_w.charge_state_change   = reg_q[`CMS_IDX_CHG][0];
	assign mask_w.watchdog_timeout      = reg_q[`CMS_IDX_TMR][3];
	assign mask_w.input_bus_timeout     = reg_q[`CMS_IDX_TMR][2];
	assign mask_w.charge_timeout        = reg_q[`CMS_IDX_TMR][1];
	assign mask_w.boost_overload_level2 = reg_q[`CMS_IDX_BST][4];
	assign mask_w.boost_overload_level1 = reg_q[`CMS_IDX_BST][3];
	assign mask_w.bus_overvoltage       = reg_q[`CMS_IDX_BST][2];
	assign mask_w.battery_out_of_range  = reg_q[`CMS_IDX_BST][1];
	assign mask_w.boost_state_change    = reg_q[`CMS_IDX_BST][0];

	// Masked events never reach the flag; recording happens elsewhere.
	cms_evt_t flag_next;
	assign flag_next = i_events & ~mask_w;

	// Set-point fields taken from the four set-point registers.
	cms_setpoint_t sp_w;
	assign sp_w.battery_voltage_code        = reg_q[`CMS_IDX_VBAT][5:0];
	assign sp_w.charge_current_high_range   = reg_q[`CMS_IDX_IBAT][7];
	assign sp_w.end_of_charge_current       = reg_q[`CMS_IDX_IBAT][6:4];
	assign sp_w.charge_current_code         = reg_q[`CMS_IDX_IBAT][3:0];
	assign sp_w.weak_battery_current        = reg_q[`CMS_IDX_MISC][6:5];
	assign sp_w.reconnect_threshold         = reg_q[`CMS_IDX_MISC][4:2];
	assign sp_w.bus_input_current_limit     = reg_q[`CMS_IDX_MISC][1:0];
	assign sp_w.adapter_input_current_limit = reg_q[`CMS_IDX_BUS_INPUT_CURRENT_LIMIT][7:4];

	// Physical values of the set-points. Codes past the documented top
	// give an extrapolated value; the host is expected not to use them.
	cms_phys_t phys_w;
	logic [12:0] bus_lim_ma;
	logic [12:0] charge_current_code_base_ma;
	assign phys_w.battery_voltage_mv = `CMS_VBAT_BASE_MV
		+ 13'(sp_w.battery_voltage_code) * `CMS_VBAT_STEP_MV;
	assign charge_current_code_base_ma = `CMS_CHARGE_CURRENT_CODE_BASE_MA
		+ 13'(sp_w.charge_current_code) * `CMS_CHARGE_CURRENT_CODE_STEP_MA;
	assign phys_w.charge_current_ma = sp_w.charge_current_high_range ?
		charge_current_code_base_ma + `CMS_CHARGE_CURRENT_HIGH_RANGE_MA : charge_current_code_base_ma;
	assign phys_w.end_of_charge_ma = `CMS_END_OF_CHARGE_CURRENT_BASE_MA
		+ 13'(sp_w.end_of_charge_current) * `CMS_END_OF_CHARGE_CURRENT_STEP_MA;
	assign phys_w.weak_battery_ma =
		13'(sp_w.weak_battery_current) * `CMS_WEAK_BATTERY_CURRENT_STEP_MA;
	assign phys_w.reconnect_mv = `CMS_VFET_BASE_MV
		+ 13'(sp_w.reconnect_threshold) * `CMS_VFET_STEP_MV;
	assign bus_lim_ma =
		(sp_w.bus_input_current_limit == 2'h0) ? `CMS_IIN_LIM0_MA :
		(sp_w.bus_input_current_limit == 2'h1) ? `CMS_IIN_LIM1_MA :
		(sp_w.bus_input_current_limit == 2'h2) ? `CMS_IIN_LIM2_MA :
		`CMS_IIN_LIM3_MA;
	assign phys_w.input_limit_ma =
		(sp_w.adapter_input_current_limit == 4'h0) ? bus_lim_ma :
		`CMS_IIN_TA_BASE_MA
		+ 13'(sp_w.adapter_input_current_limit) * `CMS_IIN_TA_STEP_MA;

	// Read port registers; power-on reset clears the answer.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
			hit_reg    <= 1'b0;
		end
		else
		begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= i_reg_rd;
			hit_reg    <= hit_next;
		end
	end

	// Output copies so that every output leaves a flip-flop.
	cms_evt_t      flag_reg;
	cms_evt_t      mask_reg;
	cms_setpoint_t sp_reg;
	cms_phys_t     phys_reg;
	always_ff @(posedge i_sys_clk)
	begin
		flag_reg <= i_sys_rst ? '0 : flag_next;
		mask_reg <= mask_w;
		sp_reg   <= sp_w;
		phys_reg <= phys_w;
	end

	assign o_reg_rdata   = rdata_reg;
	assign o_reg_rvalid  = rvalid_reg;
	assign o_reg_hit     = hit_reg;
	assign o_flag_events = flag_reg;
	assign o_mask        = mask_reg;
	assign o_setpoint    = sp_reg;
	assign o_phys        = phys_reg;
endmodule

// [cms_regs_chk.sv]
/*
 * Port assertions for the charger mask and set-point register bank.
 * Assumes it is bound to cms_regs_top and sees only its ports.
 */
`timescale 1ns/100ps
module cms_regs_chk (
	// Clock and default sources.
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_off_state,
	input  wire logic                   i_reg_reset_cmd,
	input  wire logic                   i_boost_mode_entry,
	// Register port.
	input  wire logic             [7:0] i_reg_addr,
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	input  wire logic             [7:0] o_reg_rdata,
	input  wire logic                   o_reg_rvalid,
	input  wire logic                   o_reg_hit,
	// Events and set-points.
	input  wire cms_pkg::cms_evt_t      i_events,
	input  wire cms_pkg::cms_evt_t      o_flag_events,
	input  wire cms_pkg::cms_evt_t      o_mask,
	input  wire cms_pkg::cms_setpoint_t o_setpoint,
	input  wire cms_pkg::cms_phys_t     o_phys
);
	import cms_pkg::*;
	localparam logic [24:0] SP_DEF = {6'h0C, 1'h0, 3'h2, 4'h6, 2'h1, 3'h3,
		2'h0, 4'h0};
	// Bits that must read zero at the addressed place; FF means unmapped.
	wire logic [7:0] rz = i_reg_addr == 8'h0B ? 8'hE4 :
		i_reg_addr == 8'h0C ? 8'hF1 : i_reg_addr == 8'h0D ? 8'hE0 :
		i_reg_addr == 8'h0E ? 8'hC0 : i_reg_addr == 8'h0F ? 8'h00 :
		i_reg_addr == 8'h10 ? 8'h80 : i_reg_addr == 8'h11 ? 8'h0F : 8'hFF;
	wire logic       dflt = i_off_state | i_reg_reset_cmd | i_boost_mode_entry;
	wire logic [3:0] ta = o_setpoint.adapter_input_current_limit;
	wire logic [1:0] bl = o_setpoint.bus_input_current_limit;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	a_read_valid: assert property (i_reg_rd |=> o_reg_rvalid ##1
		(o_reg_rvalid == $past(i_reg_rd))) else $error("rvalid timing wrong");
	a_reserved_zero: assert property (i_reg_rd |=>
		(o_reg_rdata & $past(rz)) == 8'h00) else $error("reserved bits set");
	a_unmapped_miss: assert property ((i_reg_rd || i_reg_wr) &&
		rz == 8'hFF |=> !o_reg_hit) else $error("unmapped hit");
	a_flag_gate: assert property (!$past(i_sys_rst) |->
		o_flag_events == ($past(i_events) & ~o_mask)) else $error("flag gate");
	a_release_dflt: assert property ($fell(i_sys_rst) |->
		o_mask == 12'h0FF && o_setpoint == SP_DEF) else $error("reset values");
	a_source_dflt: assert property (dflt |-> ##2
		o_mask == 12'h0FF && o_setpoint == SP_DEF) else $error("source default");
	a_charge_current_code_scale: assert property ($stable(o_setpoint) |->
		o_phys.charge_current_ma == 13'h1C2 + 13'h064 *
		o_setpoint.charge_current_code + (o_setpoint.charge_current_high_range ?
		13'h640 : 13'h000)) else $error("charge current scale");
	a_vbat_scale: assert property ($stable(o_setpoint) |->
		o_phys.battery_voltage_mv == 13'hCE4 + 13'h019 *
		o_setpoint.battery_voltage_code) else $error("voltage scale");
	a_limit_sel: assert property ($stable(o_setpoint) |->
		o_phys.input_limit_ma == (ta != 4'h0 ? 13'h1F4 + 13'h064 * ta :
		bl == 2'h0 ? 13'h064 : bl == 2'h1 ? 13'h1F4 : bl == 2'h2 ? 13'h384 :
		13'h5DC)) else $error("input limit select");
endmodule

// [cms_host_bfm.sv]
/*
 * Host model: drives the internal register port as the bus transport.
 * Assumes one-cycle strobes and an answer one cycle after a read.
 */
`timescale 1ns/100ps
module cms_host_bfm (
	// Clock.
	input  wire logic       i_sys_clk,
	// Register port towards the bank.
	output logic      [7:0] o_reg_addr,
	output logic            o_reg_wr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_rd,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_rvalid,
	input  wire logic       i_reg_hit
);
	// Port idle at time zero.
	initial
	begin
		o_reg_addr = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_wdata = 8'h00;
		o_reg_rd = 1'b0;
	end
	// One write strobe; released lines show inverted values.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		#1;
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_wr = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
	endtask
	// One read strobe, then a bounded wait for the answer.
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic h, output logic to);
		to = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_rd = 1'b0;
		o_reg_addr = ~a;
		for (int n = 0; n < 4 && to; n++)
		begin
			if (i_reg_rvalid === 1'b1)
			begin
				d = i_reg_rdata;
				h = i_reg_hit;
				to = 1'b0;
			end
			else
				@(posedge i_sys_clk);
		end
	endtask
endmodule

// [cms_regs_top_tb.sv]
/*
 * Self-checking bench for the charger mask and set-point register bank.
 * Assumes cms_host_bfm drives the register port and the checker is bound.
 */
`timescale 1ns/100ps
module cms_regs_top_tb;
	import cms_pkg::*;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic       [2:0] src = 3'h0;
	logic       [7:0] addr, wdata, rdata, d;
	logic             wr, rd, rvalid, hit, h, to;
	cms_evt_t         ev = '0;
	cms_evt_t         flg;
	cms_phys_t        phys;
	int               num_errors = 0;
	int               n_compared = 0;
	logic       [7:0] dv[7] = '{8'h00, 8'h0E, 8'h1F, 8'h0C, 8'h26, 8'h2C, 8'h00};
	logic       [7:0] wv[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'hFF, 8'hF7, 8'hFF};
	logic       [7:0] wm[7] = '{8'h1B, 8'h0E, 8'h1F, 8'h30, 8'hFF, 8'h77, 8'hF0};

	// Clock of 8 ns.
	always #4 clk = ~clk;

	// Design and host model.
	cms_regs_top i_dut (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_off_state(src[0]), .i_reg_reset_cmd(src[1]),
		.i_boost_mode_entry(src[2]), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .o_reg_hit(hit), .i_events(ev),
		.o_flag_events(flg), .o_mask(), .o_setpoint(), .o_phys(phys));
	cms_host_bfm i_host (.i_sys_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr),
		.o_reg_wdata(wdata), .o_reg_rd(rd), .i_reg_rdata(rdata),
		.i_reg_rvalid(rvalid), .i_reg_hit(hit));

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Reads one register and checks data and hit.
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic eh);
		i_host.rd(a, d, h, to);
		if (to)
		begin
			num_errors++;
			$display("unexpected read answer: expected 1, seen 0");
			complete_run;
		end
		else
		begin
			chk("read data", {72'h0, e}, {72'h0, d});
			chk("hit", {79'h0, eh}, {79'h0, h});
		end
	endtask
	// Writes in-range values to all seven registers.
	task automatic wr_all;
		for (int i = 0; i < 7; i++)
			i_host.wr(8'h0B + i[7:0], wv[i]);
	endtask

	// Main sequence.
	initial
	begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 7; i++)
			rdc(8'h0B + i[7:0], dv[i], 1'b1);
		rdc(8'h0A, 8'h00, 1'b0);
		$display("test reset values done");
		wr_all();
		i_host.wr(8'h12, 8'hFF);
		rdc(8'h12, 8'h00, 1'b0);
		for (int i = 0; i < 7; i++)
			rdc(8'h0B + i[7:0], wm[i], 1'b1);
		chk("phys", {2'h0, 13'h1194, 13'h0DDE, 13'h0113, 13'h012C, 13'h0E10,
			13'h07D0}, phys);
		$display("test writes done");
		@(posedge clk);
		#1;
		ev = '1;
		repeat (2) @(posedge clk);
		#1;
		chk("flags", 80'h0, {68'h0, flg});
		for (int s = 0; s < 3; s++)
		begin
			wr_all();
			@(posedge clk);
			#1;
			src = 3'h1 << s;
			@(posedge clk);
			#1;
			src = 3'h0;
			repeat (2) @(posedge clk);
			#1;
			chk("flags", 80'hF00, {68'h0, flg});
			for (int i = 0; i < 7; i++)
				rdc(8'h0B + i[7:0], dv[i], 1'b1);
		end
		$display("test default sources done");
		complete_run;
	end
endmodule

bind cms_regs_top cms_regs_chk i_chk (.*);
